/* File: design/clock_fanout_output_enable_ctrl.sv */
// two-wire configuration slave and output gating of the clock fan-out buffer
// assumes link pins and buffered input clock are sampled by clk, two flops deep
module clock_fanout_output_enable_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // serial link
    input wire logic link_clk,
    input wire logic link_data_in,
    output logic link_data_out,
    output logic link_data_oe_n,
    // clock path
    input wire logic buf_in,
    input wire logic test_oe,
    output logic [fanout_pkg::NUM_OUTPUTS-1:0] clk_out,
    output logic [fanout_pkg::NUM_OUTPUTS-1:0] clk_out_oe_n
);
    import fanout_pkg::*;

    typedef struct packed {
        logic [1:0] scl_sync;
        logic [1:0] sda_sync;
        logic [1:0] bin_sync;
        logic [1:0] oe_sync;
        logic scl_last;
        logic sda_last;
        link_state_e state;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic [1:0] byte_idx;
        logic [7:0] group_a;
        logic [7:0] group_b;
        logic [7:0] group_c;
        logic [13:0] gate;
        logic ack_drive;
        logic [13:0] out;
        logic [13:0] out_oe_n;
    } ctrl_s;

    ctrl_s st_reg;
    ctrl_s st_next;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic [13:0] want;

    // synchronised pin levels and link events
    assign scl = st_reg.scl_sync[1];
    assign sda = st_reg.sda_sync[1];
    assign scl_rise = scl && !st_reg.scl_last;
    assign scl_fall = !scl && st_reg.scl_last;
    assign start_seen = scl && st_reg.scl_last && st_reg.sda_last && !sda;
    assign stop_seen = scl && st_reg.scl_last && !st_reg.sda_last && sda;

    // map register bits onto outputs
    always_comb begin
        want = {st_reg.group_c[7:6], st_reg.group_b[7:4], st_reg.group_b[1:0],
            st_reg.group_a[7:6], st_reg.group_a[3:0]};
    end

    // next state of the whole block
    always_comb begin
        st_next = st_reg;
        st_next.scl_sync = {st_reg.scl_sync[0], link_clk};
        st_next.sda_sync = {st_reg.sda_sync[0], link_data_in};
        st_next.bin_sync = {st_reg.bin_sync[0], buf_in};
        st_next.oe_sync = {st_reg.oe_sync[0], test_oe};
        st_next.scl_last = scl;
        st_next.sda_last = sda;
        if (start_seen) begin
            st_next.state = ST_ADDR;
            st_next.bit_cnt = 4'h0;
            st_next.byte_idx = OFFSET_GROUP_A;
            st_next.ack_drive = 1'b0;
        end else if (stop_seen) begin
            st_next.state = ST_IDLE;
            st_next.ack_drive = 1'b0;
        end else begin
            unique case (st_reg.state)
                ST_IDLE, ST_IGNORE: begin
                end
                ST_ADDR, ST_DATA: begin
                    if (scl_rise) begin
                        st_next.shift = {st_reg.shift[6:0], sda};
                        st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
                    end else if (scl_fall && st_reg.bit_cnt == BITS_PER_BYTE) begin
                        st_next.bit_cnt = 4'h0;
                        if (st_reg.state == ST_ADDR) begin
                            // write to our address only
                            if (st_reg.shift == {TARGET_ADDRESS, 1'b0}) begin
                                st_next.state = ST_ADDR_ACK;
                                st_next.ack_drive = 1'b1;
                            end else begin
                                st_next.state = ST_IGNORE;
                            end
                        end else begin
                            st_next.state = ST_DATA_ACK;
                            st_next.ack_drive = 1'b1;
                            unique case (st_reg.byte_idx)
                                OFFSET_GROUP_A: st_next.group_a = st_reg.shift;
                                OFFSET_GROUP_B: st_next.group_b = st_reg.shift;
                                OFFSET_GROUP_C: st_next.group_c = st_reg.shift;
                                default: begin
                                end
                            endcase
                            if (st_reg.byte_idx != 2'h3) begin
                                st_next.byte_idx = st_reg.byte_idx + 2'h1;
                            end
                        end
                    end
                end
                ST_ADDR_ACK, ST_DATA_ACK: begin
                    if (scl_fall) begin
                        st_next.ack_drive = 1'b0;
                        st_next.state = ST_DATA;
                    end
                end
                default: st_next.state = ST_IDLE;
            endcase
        end
        // gate updates only while the input clock is low
        if (!st_reg.bin_sync[1]) begin
            st_next.gate = want;
        end
        st_next.out = st_reg.bin_sync[1] ? st_reg.gate : 14'h0000;
        st_next.out_oe_n = st_reg.oe_sync[1] ? 14'h0000 : 14'h3FFF;
    end

    // state register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '0;
            // link idles high, so no false edge follows reset
            st_reg.scl_sync <= 2'h3;
            st_reg.sda_sync <= 2'h3;
            st_reg.scl_last <= 1'b1;
            st_reg.sda_last <= 1'b1;
            st_reg.state <= ST_IDLE;
            st_reg.group_a <= RESET_GROUP_A;
            st_reg.group_b <= RESET_GROUP_B;
            st_reg.group_c <= RESET_GROUP_C;
            st_reg.gate <= 14'h3FFF;
            st_reg.out_oe_n <= 14'h3FFF;
        end else begin
            st_reg <= st_next;
        end
    end

    // pin drivers
    assign link_data_out = 1'b0;
    assign link_data_oe_n = !st_reg.ack_drive;
    assign clk_out = st_reg.out;
    assign clk_out_oe_n = st_reg.out_oe_n;

    // test pin and output path checks
    a_test_float: assert property (@(posedge clk) disable iff (!nrst)
        !st_reg.oe_sync[1] |=> clk_out_oe_n == 14'h3FFF)
        else $error("outputs not floated by test pin");
    a_drive_on: assert property (@(posedge clk) disable iff (!nrst)
        st_reg.oe_sync[1] |=> clk_out_oe_n == 14'h0000)
        else $error("outputs not driven with test pin high");
    a_follow_clk: assert property (@(posedge clk) disable iff (!nrst)
        st_reg.gate[13] |=> clk_out[13] == $past(st_reg.bin_sync[1]))
        else $error("enabled output not following clock");
    a_off_low: assert property (@(posedge clk) disable iff (!nrst)
        (st_reg.gate[0] == 1'b0) |=> clk_out[0] == 1'b0)
        else $error("disabled output not low");
    a_all_off_low: assert property (@(posedge clk) disable iff (!nrst)
        1'b1 |=> (clk_out & ~$past(st_reg.gate)) == 14'h0000)
        else $error("a disabled output is high");
    a_out_low_phase: assert property (@(posedge clk) disable iff (!nrst)
        !st_reg.bin_sync[1] |=> clk_out == 14'h0000)
        else $error("output high while input clock low");
    a_gate_low: assert property (@(posedge clk) disable iff (!nrst)
        st_reg.bin_sync[1] |=> st_reg.gate == $past(st_reg.gate))
        else $error("gate changed while input clock high");

    // enable map checks, gate loads from the groups in the low phase
    a_byte_map: assert property (@(posedge clk) disable iff (!nrst)
        !st_reg.bin_sync[1] |=> st_reg.gate[5:0] == $past({st_reg.group_a[7:6],
        st_reg.group_a[3:0]}) && st_reg.gate[13:12] == $past(st_reg.group_c[7:6]))
        else $error("byte map wrong");
    a_group_b_map: assert property (@(posedge clk) disable iff (!nrst)
        !st_reg.bin_sync[1] |=> st_reg.gate[11:6] ==
        $past({st_reg.group_b[7:4], st_reg.group_b[1:0]}))
        else $error("group b map wrong");
    a_group_write: assert property (@(posedge clk) disable iff (!nrst)
        st_reg.state == ST_DATA && scl_fall && st_reg.bit_cnt == BITS_PER_BYTE
        && st_reg.byte_idx == OFFSET_GROUP_A |=> st_reg.group_a == $past(st_reg.shift))
        else $error("first data byte not stored in group a");

    // serial link checks
    a_addr_match: assert property (@(posedge clk) disable iff (!nrst)
        st_reg.state == ST_ADDR_ACK |-> !link_data_oe_n)
        else $error("address not acknowledged");
    a_addr_only: assert property (@(posedge clk) disable iff (!nrst)
        st_reg.state == ST_ADDR && scl_fall && st_reg.bit_cnt == BITS_PER_BYTE
        && st_reg.shift != {TARGET_ADDRESS, 1'b0} |=> st_reg.state == ST_IGNORE)
        else $error("foreign address not ignored");
    a_ignore_quiet: assert property (@(posedge clk) disable iff (!nrst)
        st_reg.state == ST_IGNORE |-> link_data_oe_n)
        else $error("foreign address acknowledged");
    a_ignore_keeps: assert property (@(posedge clk) disable iff (!nrst)
        st_reg.state == ST_IGNORE |=> st_reg.group_a == $past(st_reg.group_a)
        && st_reg.group_b == $past(st_reg.group_b)
        && st_reg.group_c == $past(st_reg.group_c))
        else $error("foreign frame changed an enable byte");
    a_bit_order: assert property (@(posedge clk) disable iff (!nrst)
        (st_reg.state == ST_ADDR || st_reg.state == ST_DATA) && scl_rise
        |=> st_reg.shift == {$past(st_reg.shift[6:0]), $past(sda)})
        else $error("link bit not shifted in msb first");
    a_bit_count: assert property (@(posedge clk) disable iff (!nrst)
        (st_reg.state == ST_ADDR || st_reg.state == ST_DATA)
        |-> st_reg.bit_cnt <= BITS_PER_BYTE)
        else $error("bit counter past one byte");
    a_data_ack: assert property (@(posedge clk) disable iff (!nrst)
        st_reg.state == ST_DATA_ACK |-> !link_data_oe_n)
        else $error("data byte not acknowledged");
    a_ack_release: assert property (@(posedge clk) disable iff (!nrst)
        (st_reg.state == ST_ADDR_ACK || st_reg.state == ST_DATA_ACK) && scl_fall
        |=> link_data_oe_n && st_reg.state == ST_DATA)
        else $error("acknowledge not released after its clock");
    a_start_restart: assert property (@(posedge clk) disable iff (!nrst)
        start_seen |=> st_reg.state == ST_ADDR && st_reg.byte_idx == OFFSET_GROUP_A)
        else $error("start did not restart at group a");
    a_stop_idle: assert property (@(posedge clk) disable iff (!nrst)
        stop_seen |=> st_reg.state == ST_IDLE && link_data_oe_n)
        else $error("stop did not end the frame");
endmodule : clock_fanout_output_enable_ctrl

/* File: inc/fanout_pkg.sv */
// constants for the clock fan-out output enable control block
// assumes a 10 MHz system clock that samples the serial link pins
package fanout_pkg;
    localparam int NUM_OUTPUTS = 14;
    localparam logic [6:0] TARGET_ADDRESS = 7'h69;
    localparam logic [1:0] OFFSET_GROUP_A = 2'h0;
    localparam logic [1:0] OFFSET_GROUP_B = 2'h1;
    localparam logic [1:0] OFFSET_GROUP_C = 2'h2;
    localparam logic [7:0] RESET_GROUP_A = 8'hCF;
    localparam logic [7:0] RESET_GROUP_B = 8'hF3;
    localparam logic [7:0] RESET_GROUP_C = 8'hC0;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ADDR_ACK = 3'b010,
        ST_DATA = 3'b011,
        ST_DATA_ACK = 3'b100,
        ST_IGNORE = 3'b101
    } link_state_e;
endpackage : fanout_pkg

/* File: verification/clock_fanout_output_enable_ctrl_test.sv */
// self-checking bench of the fan-out output enable control block
// assumes the host model drives the link and a pull-up on the data line
module clock_fanout_output_enable_ctrl_test;
    timeunit 1ns;
    timeprecision 1ns;
    import fanout_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic buf_in = 1'b0;
    logic test_oe = 1'b1;
    logic buf_run = 1'b1;
    logic buf_level = 1'b1;
    logic scl, sda_rel, data_out, data_oe_n;
    logic [NUM_OUTPUTS-1:0] clk_out, clk_out_oe_n;
    wire logic sda_line = sda_rel & (data_oe_n | data_out);
    int mismatches = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [3:0] acks;
    logic [7:0] grp [3] = '{8'hFF, 8'hFF, 8'hFF};
    logic [7:0] addr_t [4] = '{{TARGET_ADDRESS, 1'b0}, 8'hD4, {TARGET_ADDRESS, 1'b1},
        {TARGET_ADDRESS, 1'b0}};
    logic [7:0] dat_t [4][3] = '{'{8'h81, 8'h91, 8'h80}, '{8'h00, 8'h00, 8'h00},
        '{8'h00, 8'h00, 8'h00}, '{8'h4A, 8'h00, 8'h00}};
    int cnt_t [4] = '{3, 3, 1, 1};
    clock_fanout_output_enable_ctrl dut (
        .clk(clk), .nrst(nrst), .link_clk(scl), .link_data_in(sda_line),
        .link_data_out(data_out), .link_data_oe_n(data_oe_n), .buf_in(buf_in),
        .test_oe(test_oe), .clk_out(clk_out), .clk_out_oe_n(clk_out_oe_n));
    config_host host (.scl(scl), .sda_rel(sda_rel), .sda_line(sda_line));
    // clock, input clock to buffer and timeout
    always #50 clk = ~clk;
    always @(negedge clk) begin
        buf_in <= buf_run ? ~buf_in : buf_level;
        cycles++;
        if (cycles > 20000) begin
            mismatches++;
            $display("unexpected at %0t: timeout", $time);
            end_of_test();
        end
    end
    // output bit order 13 down to 0 from the three groups
    function automatic logic [13:0] enable_map(input logic [7:0] a, b, c);
        return {c[7:6], b[7:4], b[1:0], a[7:6], a[3:0]};
    endfunction : enable_map
    task automatic check(input logic [13:0] got, input logic [13:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : check
    // hold the input clock low, then high: outputs show zero, then the enable mask
    task automatic look(input logic [13:0] exp);
        @(posedge clk);
        buf_run = 1'b0;
        buf_level = 1'b0;
        repeat (8) @(negedge clk);
        check(clk_out, 14'h0000, "outputs with input clock low");
        @(posedge clk) buf_level = 1'b1;
        repeat (8) @(negedge clk);
        check(clk_out, exp, "gated outputs");
        check(clk_out_oe_n, 14'h0, "drive enables");
        @(posedge clk) buf_run = 1'b1;
        @(negedge clk);
    endtask : look
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test
    // reset, test pin, then a table of frames
    initial begin
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        look(14'h3FFF);
        $display("test power-up enables done");
        test_oe = 1'b0;
        repeat (6) @(negedge clk);
        check(clk_out_oe_n, 14'h3FFF, "float with test low");
        test_oe = 1'b1;
        $display("test float done");
        for (int t = 0; t < 4; t++) begin
            host.write_cfg(addr_t[t], dat_t[t], cnt_t[t], acks);
            @(negedge clk);
            if (addr_t[t] == {TARGET_ADDRESS, 1'b0}) begin
                for (int k = 0; k < cnt_t[t]; k++) grp[k] = dat_t[t][k];
                check({10'h0, acks}, 14'((1 << (cnt_t[t] + 1)) - 1), "ack");
            end else begin
                check({10'h0, acks}, 14'h0, "ack");
            end
            look(enable_map(grp[0], grp[1], grp[2]));
            $display("test %0d done", t);
        end
        // reset in mid-run brings every enable back
        nrst = 1'b0;
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        look(14'h3FFF);
        $display("test reset restores enables done");
        end_of_test();
    end
endmodule : clock_fanout_output_enable_ctrl_test

/* File: verification/config_host.sv */
// two-wire host model that writes configuration bytes to the fan-out block
// assumes the bench resolves the open-drain data line with a pull-up
module config_host (
    // serial link
    output logic scl,
    output logic sda_rel,
    input wire logic sda_line
);
    timeunit 1ns;
    timeprecision 1ns;
    // link clock stands high and data is released between frames
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    // one byte msb first, then the acknowledge slot
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_rel = b[i];
            #200 scl = 1'b1;
            #400 scl = 1'b0;
            #200;
        end
        sda_rel = 1'b1;
        #200 scl = 1'b1;
        #200 ack = ~sda_line;
        #200 scl = 1'b0;
        #200;
    endtask : send_byte
    // start, address byte, n data bytes from byte zero up, stop
    task automatic write_cfg(input logic [7:0] addr_byte, input logic [7:0] d [3],
        input int n, output logic [3:0] acks);
        acks = 4'h0;
        sda_rel = 1'b0;
        #400 scl = 1'b0;
        #200 send_byte(addr_byte, acks[0]);
        for (int k = 0; k < n; k++) send_byte(d[k], acks[k+1]);
        sda_rel = 1'b0;
        #200 scl = 1'b1;
        #400 sda_rel = 1'b1;
        #400;
    endtask : write_cfg
endmodule : config_host
